// >>> hdl/fse_defs.vh
// Register map, field positions and reset values of the flash status block
`ifndef FSE_DEFS_VH
`define FSE_DEFS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define FSE_IDX_CONFIG       6'h04
`define FSE_IDX_ERR_CONFIG   6'h05
`define FSE_IDX_STATUS       6'h06
`define FSE_IDX_ERR_STATUS   6'h08

// ----------------------------------------------------------------------
// flash_status fields
// ----------------------------------------------------------------------
`define FSE_ST_CMD_COMPLETE  7
`define FSE_ST_ACCESS_ERR    5
`define FSE_ST_PROTECT       4
`define FSE_ST_BUSY          3
`define FSE_ST_RSVD          2
`define FSE_ST_COMPL_HI      1
`define FSE_ST_COMPL_LO      0

// ----------------------------------------------------------------------
// flash_error_status fields
// ----------------------------------------------------------------------
`define FSE_ER_DOUBLE        1
`define FSE_ER_SINGLE        0

// ----------------------------------------------------------------------
// flash_config and flash_error_config fields
// ----------------------------------------------------------------------
`define FSE_CF_CC_IRQ_EN     7
`define FSE_CF_IGNORE_SF     4
`define FSE_CF_FORCE_DF      1
`define FSE_CF_FORCE_SF      0
`define FSE_EC_DF_IRQ_EN     1
`define FSE_EC_SF_IRQ_EN     0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FSE_RST_CMD_COMPLETE 1'b1
`define FSE_RST_COMPL        2'h0
`define FSE_RST_CONFIG       8'h00
`define FSE_RST_ERR_CONFIG   8'h00

`endif

// >>> hdl/fse_flash_status.v
// Flash status and error flag register bank with APB slave
`include "fse_defs.vh"
`default_nettype none

module fse_flash_status (
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Memory controller, same clock
  input  wire        cmd_done,
  input  wire        cmd_abort,
  input  wire [1:0]  cmd_compl_status,
  input  wire        seq_violation,
  input  wire        illegal_cmd,
  input  wire        protect_hit,
  input  wire        controller_busy,
  input  wire        reset_seq_done,
  input  wire [1:0]  reset_compl_status,
  input  wire        reset_double_fault,
  input  wire        array_read,
  input  wire        read_single_fault,
  input  wire        read_double_fault,
  input  wire        read_block_busy,
  output reg         cmd_launch,
  output wire        seq_start_allowed,
  output wire        cmd_complete_flag,
  output wire        ignore_single_fault,
  output wire        force_double_fault,
  output wire        force_single_fault,
  // Interrupt requests
  output wire        cmd_complete_irq,
  output wire        fault_irq
);

  // --------------------------------------------------------------------
  // Register map (byte address = 4 x index, low byte of the word)
  // --------------------------------------------------------------------
  //   0x10  flash_config        irq enable 7, ignore single 4,
  //                             force double 1, force single 0
  //   0x14  flash_error_config  double irq enable 1, single enable 0
  //   0x18  flash_status        complete 7, access err 5, protect 4,
  //                             busy 3, completion status 1:0
  //   0x20  flash_error_status  double fault 1, single fault 0
  // Any other address answers with pslverr and has no effect.
  // Launching and clearing errors in one write is refused: the errors
  // are judged as they stood before the write, so software clears them
  // first and then launches.

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Byte address of a register index
  function [7:0] addr_of;
    input [5:0] idx;
    begin
      addr_of = {idx, 2'b00};
    end
  endfunction

  // Sticky flag: a hardware set wins over a same-cycle write-1 clear
  function w1c_next;
    input flag;
    input set;
    input clr;
    begin
      w1c_next = set | (flag & ~clr);
    end
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg        cmd_complete_q;
  reg        cmd_complete_d;
  reg        access_error_q;
  reg        access_error_d;
  reg        protect_q;
  reg        protect_d;
  reg  [1:0] compl_status_q;
  reg  [1:0] compl_status_d;
  reg        double_fault_q;
  reg        double_fault_d;
  reg        single_fault_q;
  reg        single_fault_d;
  reg  [7:0] config_q;
  reg  [7:0] err_config_q;
  reg  [7:0] config_d;
  reg  [7:0] err_config_d;
  reg        launch_d;
  reg  [31:0] rdata_d;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire sel_cfg  = (paddr == addr_of(`FSE_IDX_CONFIG));
  wire sel_ecfg = (paddr == addr_of(`FSE_IDX_ERR_CONFIG));
  wire sel_st   = (paddr == addr_of(`FSE_IDX_STATUS));
  wire sel_est  = (paddr == addr_of(`FSE_IDX_ERR_STATUS));
  wire hit      = sel_cfg | sel_ecfg | sel_st | sel_est;
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire wr       = access & pwrite & hit;

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;

  wire wr_st  = wr & sel_st;
  wire wr_est = wr & sel_est;

  // --------------------------------------------------------------------
  // Status register view
  // --------------------------------------------------------------------
  wire [7:0] status_view;
  assign status_view[`FSE_ST_CMD_COMPLETE] = cmd_complete_q;
  assign status_view[6]                    = 1'b0;
  assign status_view[`FSE_ST_ACCESS_ERR]   = access_error_q;
  assign status_view[`FSE_ST_PROTECT]      = protect_q;
  assign status_view[`FSE_ST_BUSY]         = controller_busy;
  assign status_view[`FSE_ST_RSVD]         = 1'b0;
  assign status_view[`FSE_ST_COMPL_HI:`FSE_ST_COMPL_LO] = compl_status_q;

  wire [7:0] err_status_view = {6'h00, double_fault_q, single_fault_q};

  // --------------------------------------------------------------------
  // Command launch and status flags
  // --------------------------------------------------------------------
  // Launch needs the flag set and the access error and protect flags clear as they stood
  // before this write, so clearing an error and launching in one write
  // still fails; software must clear the errors first.
  wire launch_req = wr_st & pwdata[`FSE_ST_CMD_COMPLETE];
  wire launch_ok  = cmd_complete_q & ~access_error_q & ~protect_q;

  always @* begin
    launch_d       = launch_req & launch_ok;
    cmd_complete_d = cmd_complete_q;
    if (launch_d) begin
      cmd_complete_d = 1'b0;
    end else if (~cmd_complete_q & (cmd_done | cmd_abort)) begin
      cmd_complete_d = 1'b1;
    end
  end

  always @* begin
    access_error_d = w1c_next(access_error_q,
                              seq_violation | illegal_cmd,
                              wr_st & pwdata[`FSE_ST_ACCESS_ERR]);
    protect_d      = w1c_next(protect_q, protect_hit,
                              wr_st & pwdata[`FSE_ST_PROTECT]);
  end

  always @* begin
    compl_status_d = compl_status_q;
    if (reset_seq_done) begin
      compl_status_d = reset_compl_status;
    end else if (launch_d) begin
      compl_status_d = 2'h0;
    end else if (~cmd_complete_q & (cmd_done | cmd_abort)) begin
      compl_status_d = cmd_compl_status;
    end
  end

  // --------------------------------------------------------------------
  // Error status flags
  // --------------------------------------------------------------------
  wire rd_busy   = array_read & read_block_busy;
  wire df_event  = (array_read & read_double_fault)
                 | (array_read & config_q[`FSE_CF_FORCE_DF])
                 | rd_busy
                 | (reset_seq_done & reset_double_fault);
  wire sf_event  = ~config_q[`FSE_CF_IGNORE_SF]
                 & ((array_read & read_single_fault)
                  | (array_read & config_q[`FSE_CF_FORCE_SF])
                  | rd_busy);

  always @* begin
    double_fault_d = w1c_next(double_fault_q, df_event,
                              wr_est & pwdata[`FSE_ER_DOUBLE]);
    single_fault_d = w1c_next(single_fault_q, sf_event,
                              wr_est & pwdata[`FSE_ER_SINGLE]);
  end

  // --------------------------------------------------------------------
  // Read data, captured in the setup cycle
  // --------------------------------------------------------------------
  always @* begin
    rdata_d = 32'h0000_0000;
    if (sel_cfg) begin
      rdata_d[7:0] = config_q;
    end else if (sel_ecfg) begin
      rdata_d[7:0] = err_config_q;
    end else if (sel_st) begin
      rdata_d[7:0] = status_view;
    end else if (sel_est) begin
      rdata_d[7:0] = err_status_view;
    end
  end

  // --------------------------------------------------------------------
  // Control register next values
  // --------------------------------------------------------------------
  // Only the documented control bits are writable; others stay 0
  always @* begin
    config_d     = config_q;
    err_config_d = err_config_q;
    if (wr & sel_cfg) begin
      config_d = pwdata[7:0] & 8'h93;
    end
    if (wr & sel_ecfg) begin
      err_config_d = pwdata[7:0] & 8'h03;
    end
  end

  // --------------------------------------------------------------------
  // Timing seen from the bus
  // --------------------------------------------------------------------
  // A write takes effect at the edge that ends its access phase; flags
  // and cmd_launch show the result one cycle later. A controller event
  // in that same cycle is merged, and a set wins over a clear.
  // pready is tied high, so a transfer never takes more than two cycles.
  // controller_busy reaches the status byte without a register, so a
  // read shows the busy level as it stood at the setup edge.
  // Completion status is cleared by a launch and loaded when the
  // command ends, or when the reset sequence of the array finishes.

  // --------------------------------------------------------------------
  // Status flag registers
  // --------------------------------------------------------------------
  // The complete flag resets to 1 so software may launch at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_complete_q <= `FSE_RST_CMD_COMPLETE;
    end else begin
      cmd_complete_q <= cmd_complete_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_error_q <= 1'b0;
    end else begin
      access_error_q <= access_error_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_q <= 1'b0;
    end else begin
      protect_q <= protect_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compl_status_q <= `FSE_RST_COMPL;
    end else begin
      compl_status_q <= compl_status_d;
    end
  end

  // --------------------------------------------------------------------
  // Error flag registers
  // --------------------------------------------------------------------
  // Sticky until written 1; a same-cycle set keeps them 1
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_fault_q <= 1'b0;
    end else begin
      double_fault_q <= double_fault_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_fault_q <= 1'b0;
    end else begin
      single_fault_q <= single_fault_d;
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= `FSE_RST_CONFIG;
    end else begin
      config_q <= config_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_config_q <= `FSE_RST_ERR_CONFIG;
    end else begin
      err_config_q <= err_config_d;
    end
  end

  // --------------------------------------------------------------------
  // Bus and controller outputs
  // --------------------------------------------------------------------
  // Launch is a one-cycle pulse, the cycle after the write edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_launch <= 1'b0;
    end else begin
      cmd_launch <= launch_d;
    end
  end

  // Read data loads at setup so it stands through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (setup & ~pwrite) ? rdata_d : prdata;
    end
  end

  // --------------------------------------------------------------------
  // Outputs to the controller and interrupt requests
  // --------------------------------------------------------------------
  assign seq_start_allowed   = ~protect_q;
  assign cmd_complete_flag   = cmd_complete_q;
  assign ignore_single_fault = config_q[`FSE_CF_IGNORE_SF];
  assign force_double_fault  = config_q[`FSE_CF_FORCE_DF];
  assign force_single_fault  = config_q[`FSE_CF_FORCE_SF];

  assign cmd_complete_irq = cmd_complete_q
                          & config_q[`FSE_CF_CC_IRQ_EN];
  assign fault_irq = (double_fault_q & err_config_q[`FSE_EC_DF_IRQ_EN])
                   | (single_fault_q
                      & err_config_q[`FSE_EC_SF_IRQ_EN]);

endmodule

`default_nettype wire

// >>> verif/flash_status_error_flags_tb_top.sv
// Self-checking bench of the flash status and error flag bank
`default_nettype none
module flash_status_error_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [8:0]  ev = 9'h000;
  logic [7:0]  lat = 8'h02;
  logic        abort = 1'b0;
  logic [1:0]  stat = 2'h0;
  logic [31:0] q;
  int          miscompares = 0;
  int          tests_run = 0;
  wire         pready, done, abt, busy, launch, ccf;
  wire         slverr, ssa, cc_irq, f_irq;
  logic        se;
  wire  [1:0]  cstat;
  wire  [31:0] prdata;
  // Row: events, write address, write data, read address, expected
  logic [40:0] rows [22] = '{
    {9'h001, 8'h18, 8'h00, 8'h18, 8'ha0},
    {9'h000, 8'h18, 8'h80, 8'h18, 8'ha0},
    {9'h000, 8'h18, 8'h20, 8'h18, 8'h80},
    {9'h002, 8'h18, 8'h00, 8'h18, 8'ha0},
    {9'h001, 8'h18, 8'h20, 8'h18, 8'ha0},
    {9'h000, 8'h18, 8'h20, 8'h18, 8'h80},
    {9'h004, 8'h18, 8'h00, 8'h18, 8'h90},
    {9'h000, 8'h18, 8'h80, 8'h18, 8'h90},
    {9'h000, 8'h18, 8'h10, 8'h18, 8'h80},
    {9'h000, 8'h18, 8'h4c, 8'h18, 8'h80},
    {9'h028, 8'h20, 8'h00, 8'h20, 8'h02},
    {9'h018, 8'h20, 8'h02, 8'h20, 8'h01},
    {9'h018, 8'h20, 8'h01, 8'h20, 8'h01},
    {9'h000, 8'h20, 8'h01, 8'h20, 8'h00},
    {9'h048, 8'h20, 8'h00, 8'h20, 8'h03},
    {9'h000, 8'h20, 8'hff, 8'h20, 8'h00},
    {9'h000, 8'h10, 8'h10, 8'h10, 8'h10},
    {9'h018, 8'h20, 8'h00, 8'h20, 8'h00},
    {9'h008, 8'h10, 8'h02, 8'h20, 8'h00},
    {9'h008, 8'h04, 8'hff, 8'h20, 8'h02},
    {9'h180, 8'h20, 8'h02, 8'h20, 8'h02},
    {9'h000, 8'h10, 8'h00, 8'h18, 8'h82}};
  fse_flash_status i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(slverr), .cmd_done(done), .cmd_abort(abt),
    .cmd_compl_status(cstat), .seq_violation(ev[0]),
    .illegal_cmd(ev[1]), .protect_hit(ev[2]), .controller_busy(busy),
    .reset_seq_done(ev[7]), .reset_compl_status(2'h2),
    .reset_double_fault(ev[8]), .array_read(ev[3]),
    .read_single_fault(ev[4]), .read_double_fault(ev[5]),
    .read_block_busy(ev[6]), .cmd_launch(launch),
    .seq_start_allowed(ssa), .cmd_complete_flag(ccf),
    .ignore_single_fault(), .force_double_fault(),
    .force_single_fault(), .cmd_complete_irq(cc_irq), .fault_irq(f_irq));
  fse_ctrl_model i_ctrl (
    .pclk(pclk), .presetn(presetn), .cmd_launch(launch), .lat(lat),
    .abort(abort), .stat(stat), .controller_busy(busy),
    .cmd_done(done), .cmd_abort(abt), .cmd_compl_status(cstat));
  always #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Controller events ride the access phase, hitting the write edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [8:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    ev <= e;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    se = slverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ev <= 9'h000;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, 9'h000);
    chk(q, x);
  endtask
  task automatic test_done();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i][31:24], {24'h00_0000, rows[i][23:16]},
          rows[i][40:32]);
      rdc(rows[i][15:8], {24'h00_0000, rows[i][7:0]});
    end
    apb(1'b1, 8'h04, 32'h0000_00ff, 9'h000);
    chk({31'h0, se}, 32'h0000_0001);
    apb(1'b1, 8'h14, 32'h0000_00ff, 9'h028);
    rdc(8'h14, 32'h0000_0003);
    chk({31'h0, f_irq}, 32'h0000_0001);
    apb(1'b1, 8'h20, 32'h0000_0002, 9'h000);
    rdc(8'h20, 32'h0000_0000);
    chk({31'h0, f_irq}, 32'h0000_0000);
    apb(1'b1, 8'h10, 32'h0000_0080, 9'h000);
    rdc(8'h10, 32'h0000_0080);
    chk({31'h0, cc_irq}, 32'h0000_0001);
    apb(1'b1, 8'h18, 32'h0000_0000, 9'h004);
    rdc(8'h18, 32'h0000_0092);
    chk({31'h0, ssa}, 32'h0000_0000);
    apb(1'b1, 8'h18, 32'h0000_0010, 9'h000);
    rdc(8'h18, 32'h0000_0082);
    chk({31'h0, ssa}, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      lat <= (i == 0) ? 8'h14 : 8'h02;
      abort <= (i == 1);
      stat <= 2'(i + 1);
      apb(1'b1, 8'h18, 32'h0000_0080, 9'h000);
      rdc(8'h18, 32'h0000_0008);
      if (i == 0) begin
        chk({31'h0, cc_irq}, 32'h0000_0000);
        apb(1'b1, 8'h18, 32'h0000_0080, 9'h000);
      end
      for (int n = 0; n < 60 && ccf !== 1'b1; n++)
        @(posedge pclk);
      rdc(8'h18, 32'h0000_0080 + 32'(i + 1));
    end
    apb(1'b1, 8'h10, 32'h0000_0012, 9'h028);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h18, 32'h0000_0080);
    rdc(8'h20, 32'h0000_0000);
    rdc(8'h10, 32'h0000_0000);
    test_done();
  end
endmodule
`default_nettype wire

// >>> verif/fse_ctrl_model.sv
// Behavioural memory controller that runs launched commands
`default_nettype none
module fse_ctrl_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cmd_launch,
  input  wire logic [7:0] lat,
  input  wire logic       abort,
  input  wire logic [1:0] stat,
  output logic            controller_busy,
  output logic            cmd_done,
  output logic            cmd_abort,
  output logic [1:0]      cmd_compl_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic       fin;
  // A latency of 1 or more keeps busy visible to the first read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_q <= 8'h00;
    else if (cmd_launch)
      cnt_q <= lat;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  assign fin = cnt_q == 8'h01;
  assign controller_busy = cnt_q != 8'h00;
  assign cmd_done = fin & ~abort;
  assign cmd_abort = fin & abort;
  // Status is only meaningful in the end pulse, so it shows the inverted value elsewhere
  assign cmd_compl_status = fin ? stat : ~stat;
endmodule
`default_nettype wire

// >>> verif/fse_flash_status_sva.sv
// Port checks of the flash status bank
`include "fse_defs.vh"
`default_nettype none
module fse_flash_status_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        cmd_done,
  input wire logic        cmd_abort,
  input wire logic        controller_busy,
  input wire logic        cmd_launch,
  input wire logic        seq_start_allowed,
  input wire logic        cmd_complete_flag,
  input wire logic        cmd_complete_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ST = {`FSE_IDX_STATUS, 2'b00};
  logic st_wr;
  logic st_rd;
  assign st_wr = psel && penable && pwrite && paddr == ST;
  assign st_rd = psel && !penable && !pwrite && paddr == ST;
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  launch_cause_a: assert property (cmd_launch |->
    $past(st_wr && pwdata[7] && cmd_complete_flag)) else $error("bad launch");
  launch_clears_a: assert property (cmd_launch |->
    !cmd_complete_flag) else $error("flag not cleared by launch");
  flag_hold_a: assert property (!cmd_complete_flag && !cmd_done &&
    !cmd_abort |=> !cmd_complete_flag) else $error("flag rose early");
  done_sets_a: assert property ((cmd_done || cmd_abort) |=>
    cmd_complete_flag) else $error("flag not set at end");
  protect_block_a: assert property ($past(!seq_start_allowed) |->
    !cmd_launch) else $error("launch under protect flag");
  rsvd_zero_a: assert property ($past(st_rd) |-> prdata[2] == 1'b0 &&
    prdata[6] == 1'b0 && prdata[31:8] == 24'h00_0000) else $error("rsvd set");
  busy_view_a: assert property ($past(st_rd) |->
    prdata[3] == $past(controller_busy)) else $error("busy bit wrong");
  irq_flag_a: assert property (cmd_complete_irq |->
    cmd_complete_flag) else $error("irq without flag");
endmodule
bind fse_flash_status fse_flash_status_sva i_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .cmd_done(cmd_done),
  .cmd_abort(cmd_abort), .controller_busy(controller_busy),
  .cmd_launch(cmd_launch), .seq_start_allowed(seq_start_allowed),
  .cmd_complete_flag(cmd_complete_flag),
  .cmd_complete_irq(cmd_complete_irq));
`default_nettype wire
